// ==== ssp_pkg.sv ====
/*
 Shared constants and types for the synchronous serial port block.
 Assumes nothing beyond a SystemVerilog compiler; imported by ssp_sync_port.
*/
`default_nettype none
package ssp_pkg;
   localparam int unsigned FIFO_DEPTH = 2;
   localparam logic [1:0]  FIFO_FULL  = 2'h2;
   localparam logic [1:0]  FIFO_NONE  = 2'h0;
   localparam logic [1:0]  FIFO_ONE   = 2'h1;
   localparam logic [3:0]  LAST_BIT_8 = 4'h7;
   localparam logic [3:0]  LAST_BIT_9 = 4'h8;
   localparam logic [3:0]  BIT_ZERO   = 4'h0;
   localparam logic [3:0]  BIT_STEP   = 4'h1;
   localparam int unsigned NINTH_POS  = 8;
   localparam int unsigned CHAR_W     = 9;
   localparam logic [8:0]  WORD_ZERO  = 9'h000;
   localparam logic [15:0] DIV_ZERO   = 16'h0000;
   localparam logic [15:0] DIV_STEP   = 16'h0001;

   typedef enum logic [1:0] {
      SSP_M_IDLE  = 2'b00,
      SSP_M_LEAD  = 2'b01,
      SSP_M_TRAIL = 2'b10
   } ssp_mstate_t;
endpackage
`default_nettype wire

// ==== ssp_sync_port.sv ====
/*
 Synchronous half-duplex serial port: master clock generation, master
 receive into a two-entry FIFO, master and slave transmit with a holding
 register. Assumes the clock pin's input is wired to linkClk, the data
 pin is resolved outside from dataPinOut/dataPinOe, and control bits are
 driven by logic on core_clk.
*/
`default_nettype none
// Overview of operation
// - master receive turns off the data pin driver
// - either receive enable starts reception in synchronous master mode
// - single receive clocks one character then clears its own enable
// - continuous receive clocks until cleared; mid-character clear aborts, drops partial
// - both enables set: single clears after first character, continuous carries on
// - data pin sampled at trailing clock edge into receive shift register
// - completed character sets ready flag and enters two-entry FIFO; low byte readable
// - ready flag stays set while FIFO holds any unread character
// - slave mode turns off the clock pin driver, clock comes from link
// - data changes on leading edge, valid at trailing; one bit per clock
// - third character into full FIFO sets overrun, stored characters kept
// - while overrun, no more characters accepted; stored ones stay readable
// - single-mode overrun clears on read; continuous on enable clear
// - clearing port enable resets FIFO count, overrun, single enable and transmit registers
// - nine-bit receive shifts nine bits; ninth bit of oldest entry shown
// - clocked mode selects synchronous; clock source clear means slave
// - both receive enables clear gives transmit direction, else receive
// - two writes as slave: first shifts out, second held, empty flag low
// - after first word leaves, second loads and empty flag sets in the same cycle
// - idle polarity bit: set idles high, clear idles low
// - written word waits while shift register busy, else moves at once
// - master drives clock pin, one cycle per data bit, no extras
module ssp_sync_port
   import ssp_pkg::*;
#(parameter int unsigned RX_DEPTH = FIFO_DEPTH)
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       linkClk,
   input  wire logic       serialPortEn,
   input  wire logic       clockedModeSel,
   input  wire logic       clockSourceSel,
   input  wire logic       continuousRxEn,
   input  wire logic       singleRxSet,
   input  wire logic       nineBitRxSel,
   input  wire logic       nineBitTxSel,
   input  wire logic       transmitEn,
   input  wire logic       clockIdlePol,
   input  wire logic [7:0] baudDivisorHigh,
   input  wire logic [7:0] baudDivisorLow,
   input  wire logic       txWrite,
   input  wire logic [7:0] txData,
   input  wire logic       txNinthBit,
   input  wire logic       rxRead,
   input  wire logic       dataPinIn,
   output logic            dataPinOut,
   output logic            dataPinOe,
   output logic            clkPinOut,
   output logic            clkPinOe,
   output logic [7:0]      rxData,
   output logic            rxNinthBit,
   output logic            rxReadyFlag,
   output logic            overrunFlag,
   output logic            singleRxEn,
   output logic            txBufEmptyFlag,
   output logic            tsrEmpty
);

   // mode decode
   logic        syncOn, masterOn, slaveOn, rxDir;
   logic [15:0] divisor;

   // master sequencer
   ssp_mstate_t mState_ff;
   logic [15:0] baudCnt_ff;
   logic [3:0]  bitCnt_ff, charLast_ff;
   logic [8:0]  rsr_ff;
   logic        curRx_ff, clkPin_ff, mTxBit_ff, rxDone_ff, mTxDone_ff;
   logic        startOk, keepOk, trailEdge, lastEdge;

   // data pin synchroniser
   logic        dS1_ff, dS2_ff, dS3_ff, dIn_ff;

   // receive FIFO
   logic [8:0]  fifo_ff [RX_DEPTH];
   logic [1:0]  count_ff;
   logic        rdPtr_ff, overrun_ff, ovrSingle_ff, single_ff;
   logic        pop, push, fifoFull, ovrHit, wrPtr;

   // transmit path
   logic [8:0]  holdWord_ff, tsrWord_ff;
   logic        holdNine_ff, holdFull_ff, tsrNine_ff, tsrFull_ff, tsrDone, tsrFree;

   // link domain and its crossing
   logic [3:0]  takenCnt_ff, showIdx_ff, slaveLast;
   logic        doneTgl_ff, lS1_ff, lS2_ff, lS3_ff, lSeen_ff, slaveDone;

   // one-bit pointers and a two-bit count serve only the two-entry FIFO
   if (RX_DEPTH != FIFO_DEPTH) begin
      $error("receive FIFO depth must be two");
   end

   assign syncOn   = serialPortEn & clockedModeSel;
   assign masterOn = syncOn & clockSourceSel;
   assign slaveOn  = syncOn & ~clockSourceSel;
   assign rxDir    = single_ff | continuousRxEn;
   assign divisor  = {baudDivisorHigh, baudDivisorLow};

   // overrun blocks new receive frames; transmit needs a loaded shift register
   assign startOk = masterOn & (rxDir ? ~overrun_ff : (transmitEn & tsrFull_ff));
   assign keepOk  = masterOn & (~curRx_ff | (rxDir & ~overrun_ff));
   assign trailEdge = (mState_ff == SSP_M_LEAD) & keepOk & (baudCnt_ff == DIV_ZERO);
   assign lastEdge  = trailEdge & (bitCnt_ff == charLast_ff);

   // data pin: three flops, a change counts once the second and third agree
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dS1_ff <= 1'b0;
         dS2_ff <= 1'b0;
         dS3_ff <= 1'b0;
         dIn_ff <= 1'b0;
      end else begin
         dS1_ff <= dataPinIn;
         dS2_ff <= dS1_ff;
         dS3_ff <= dS2_ff;
         if (dS2_ff == dS3_ff) begin
            dIn_ff <= dS3_ff;
         end
      end
   end

   // master clock sequencer: half period of divisor+1 core cycles
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mState_ff   <= SSP_M_IDLE;
         baudCnt_ff  <= DIV_ZERO;
         bitCnt_ff   <= BIT_ZERO;
         charLast_ff <= LAST_BIT_8;
         curRx_ff    <= 1'b0;
         clkPin_ff   <= 1'b0;
         mTxBit_ff   <= 1'b0;
         rsr_ff      <= WORD_ZERO;
      end else if (!keepOk && mState_ff != SSP_M_IDLE) begin
         mState_ff <= SSP_M_IDLE;
         clkPin_ff <= clockIdlePol;
         bitCnt_ff <= BIT_ZERO;
      end else begin
         case (mState_ff)
            SSP_M_IDLE: begin
               clkPin_ff  <= clockIdlePol;
               bitCnt_ff  <= BIT_ZERO;
               baudCnt_ff <= divisor;
               if (startOk) begin
                  mState_ff   <= SSP_M_LEAD;
                  clkPin_ff   <= ~clockIdlePol;
                  curRx_ff    <= rxDir;
                  rsr_ff      <= WORD_ZERO;
                  mTxBit_ff   <= tsrWord_ff[0];
                  if (rxDir) begin
                     charLast_ff <= nineBitRxSel ? LAST_BIT_9 : LAST_BIT_8;
                  end else begin
                     charLast_ff <= tsrNine_ff ? LAST_BIT_9 : LAST_BIT_8;
                  end
               end
            end
            SSP_M_LEAD: begin
               if (baudCnt_ff == DIV_ZERO) begin
                  mState_ff  <= SSP_M_TRAIL;
                  clkPin_ff  <= clockIdlePol;
                  baudCnt_ff <= divisor;
                  bitCnt_ff  <= bitCnt_ff + BIT_STEP;
                  if (curRx_ff) begin
                     rsr_ff[bitCnt_ff] <= dIn_ff;
                  end
               end else begin
                  baudCnt_ff <= baudCnt_ff - DIV_STEP;
               end
            end
            SSP_M_TRAIL: begin
               if (baudCnt_ff != DIV_ZERO) begin
                  baudCnt_ff <= baudCnt_ff - DIV_STEP;
               end else if (bitCnt_ff > charLast_ff) begin
                  mState_ff <= SSP_M_IDLE;
               end else begin
                  mState_ff  <= SSP_M_LEAD;
                  clkPin_ff  <= ~clockIdlePol;
                  baudCnt_ff <= divisor;
                  mTxBit_ff  <= tsrWord_ff[bitCnt_ff];
               end
            end
            default: begin
               mState_ff <= SSP_M_IDLE;
            end
         endcase
      end
   end

   // one-cycle completion pulses, one cycle after the last trailing edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rxDone_ff  <= 1'b0;
         mTxDone_ff <= 1'b0;
      end else begin
         rxDone_ff  <= lastEdge & curRx_ff;
         mTxDone_ff <= lastEdge & ~curRx_ff;
      end
   end

   // receive FIFO and overrun
   assign fifoFull = (count_ff == FIFO_FULL);
   assign pop      = rxRead & (count_ff != FIFO_NONE);
   assign ovrHit   = rxDone_ff & ~overrun_ff & fifoFull & ~pop;
   assign push     = rxDone_ff & ~overrun_ff & ~ovrHit;
   assign wrPtr    = rdPtr_ff ^ count_ff[0];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count_ff <= FIFO_NONE;
         rdPtr_ff <= 1'b0;
      end else if (!serialPortEn) begin
         count_ff <= FIFO_NONE;
         rdPtr_ff <= 1'b0;
      end else begin
         if (pop) begin
            rdPtr_ff <= ~rdPtr_ff;
         end
         count_ff <= count_ff + (push ? FIFO_ONE : FIFO_NONE)
                     - (pop ? FIFO_ONE : FIFO_NONE);
      end
   end

   // storage only; not cleared by the port enable so stale words linger
   always_ff @(posedge core_clk) begin
      if (push) begin
         fifo_ff[wrPtr] <= (charLast_ff == LAST_BIT_9) ? rsr_ff
                           : {1'b0, rsr_ff[NINTH_POS-1:0]};
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         overrun_ff   <= 1'b0;
         ovrSingle_ff <= 1'b0;
      end else if (!serialPortEn) begin
         overrun_ff <= 1'b0;
      end else if (ovrHit) begin
         overrun_ff   <= 1'b1;
         ovrSingle_ff <= ~continuousRxEn;
      end else if (ovrSingle_ff ? rxRead : ~continuousRxEn) begin
         overrun_ff <= 1'b0;
      end
   end

   // single receive enable: set by software pulse, cleared by a finished character
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         single_ff <= 1'b0;
      end else if (singleRxSet) begin
         single_ff <= 1'b1;
      end else if (rxDone_ff || !serialPortEn) begin
         single_ff <= 1'b0;
      end
   end

   // transmit holding and shift registers
   assign tsrDone = mTxDone_ff | slaveDone;
   assign tsrFree = ~tsrFull_ff | tsrDone;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tsrFull_ff  <= 1'b0;
         holdFull_ff <= 1'b0;
         tsrWord_ff  <= WORD_ZERO;
         tsrNine_ff  <= 1'b0;
         holdWord_ff <= WORD_ZERO;
         holdNine_ff <= 1'b0;
      end else if (!serialPortEn) begin
         tsrFull_ff  <= 1'b0;
         holdFull_ff <= 1'b0;
      end else begin
         if (tsrFree && holdFull_ff) begin
            tsrWord_ff  <= holdWord_ff;
            tsrNine_ff  <= holdNine_ff;
            tsrFull_ff  <= 1'b1;
            holdFull_ff <= txWrite;
         end else if (tsrFree && txWrite) begin
            tsrWord_ff <= {txNinthBit, txData};
            tsrNine_ff <= nineBitTxSel;
            tsrFull_ff <= 1'b1;
         end else if (tsrFree) begin
            tsrFull_ff <= 1'b0;
         end else if (txWrite) begin
            holdFull_ff <= 1'b1;
         end
         if (txWrite) begin
            holdWord_ff <= {txNinthBit, txData};
            holdNine_ff <= nineBitTxSel;
         end
      end
   end

   // link domain: one bit per link clock; counts trailing (falling) edges
   assign slaveLast = tsrNine_ff ? LAST_BIT_9 : LAST_BIT_8;

   always_ff @(negedge linkClk or posedge reset) begin
      if (reset) begin
         takenCnt_ff <= BIT_ZERO;
         doneTgl_ff  <= 1'b0;
      end else if (takenCnt_ff == slaveLast) begin
         takenCnt_ff <= BIT_ZERO;
         doneTgl_ff  <= ~doneTgl_ff;
      end else begin
         takenCnt_ff <= takenCnt_ff + BIT_STEP;
      end
   end

   // next bit is presented at the leading (rising) edge
   always_ff @(posedge linkClk or posedge reset) begin
      if (reset) begin
         showIdx_ff <= BIT_ZERO;
      end else begin
         showIdx_ff <= takenCnt_ff;
      end
   end

   // done toggle into core domain; only the agreed level is compared
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lS1_ff   <= 1'b0;
         lS2_ff   <= 1'b0;
         lS3_ff   <= 1'b0;
         lSeen_ff <= 1'b0;
      end else begin
         lS1_ff <= doneTgl_ff;
         lS2_ff <= lS1_ff;
         lS3_ff <= lS2_ff;
         if (lS2_ff == lS3_ff) begin
            lSeen_ff <= lS3_ff;
         end
      end
   end

   assign slaveDone = (lS2_ff == lS3_ff) & (lS3_ff != lSeen_ff) & slaveOn & tsrFull_ff;

   // pins and status
   assign dataPinOe   = syncOn & ~rxDir & transmitEn;
   // slave bit mux: word held stable across a frame, index steps at each leading edge
   assign dataPinOut  = masterOn ? mTxBit_ff : tsrWord_ff[showIdx_ff];
   assign clkPinOe    = masterOn;
   assign clkPinOut   = clkPin_ff;
   assign rxData      = fifo_ff[rdPtr_ff][NINTH_POS-1:0];
   assign rxNinthBit  = fifo_ff[rdPtr_ff][NINTH_POS];
   assign rxReadyFlag = (count_ff != FIFO_NONE);
   assign overrunFlag = overrun_ff;
   assign singleRxEn  = single_ff;
   assign txBufEmptyFlag = ~holdFull_ff;
   assign tsrEmpty    = ~tsrFull_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   rx_driver_off_a: assert property (masterOn && rxDir |-> !dataPinOe)
      else $error("data driver on during master receive");
   slave_clk_off_a: assert property (slaveOn |-> !clkPinOe)
      else $error("clock driver on in slave mode");
   single_self_clear_a: assert property (rxDone_ff && !singleRxSet |=> !singleRxEn)
      else $error("single receive enable not cleared");
   abort_stop_a: assert property (curRx_ff && mState_ff != SSP_M_IDLE && !rxDir
      |=> mState_ff == SSP_M_IDLE && clkPinOut == $past(clockIdlePol))
      else $error("clock did not stop on receive abort");
   ready_last_pop_a: assert property (count_ff == FIFO_ONE && pop && !push
      |=> !rxReadyFlag)
      else $error("ready flag held with empty FIFO");
   overrun_keep_a: assert property (ovrHit |=> overrunFlag && count_ff == FIFO_FULL
      && rxData == $past(rxData))
      else $error("overrun lost or data overwritten");
   overrun_block_a: assert property (overrun_ff |-> !push)
      else $error("character accepted during overrun");
   port_reset_a: assert property (!serialPortEn |=> !overrunFlag && !rxReadyFlag)
      else $error("port enable clear did not reset");
   hold_to_tsr_a: assert property (tsrDone && holdFull_ff && !txWrite
      |=> txBufEmptyFlag && !tsrEmpty)
      else $error("held word not moved on shift done");
   direct_load_a: assert property (serialPortEn && txWrite && tsrEmpty && !holdFull_ff
      |=> !tsrEmpty && txBufEmptyFlag)
      else $error("write did not go straight to shift register");
   idle_level_a: assert property (mState_ff == SSP_M_IDLE ##1 mState_ff == SSP_M_IDLE
      |-> clkPinOut == $past(clockIdlePol))
      else $error("master clock not idle between frames");

endmodule
`default_nettype wire

// ==== ssp_far_end.sv ====
/*
 Model of the far-side synchronous device: answers as slave transmitter
 while the port masters the clock, and clocks the port as slave.
 Assumes the bench resolves the data wire and pulses frameRst between frames.
*/
`default_nettype none
module ssp_far_end (
   input  wire logic       clkPin,
   input  wire logic       idlePol,
   input  wire logic       frameRst,
   input  wire logic       dataLine,
   input  wire logic [8:0] sendWord,
   input  wire logic       nineBits,
   output logic            farData,
   output logic            linkClk,
   output logic [8:0]      gotWord,
   output logic [8:0]      mstWord
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] idx;
   logic [3:0] tIdx;
   logic       lead;
   assign lead = clkPin ^ idlePol;
   initial begin
      farData = 1'b1;
      linkClk = 1'b0;
      gotWord = 9'h000;
   end
   // new bit on each leading edge, valid through the trailing edge
   always @(posedge lead or posedge frameRst) begin
      if (frameRst) begin
         idx <= 4'h0;
      end else begin
         farData <= sendWord[idx];
         idx <= (idx == (nineBits ? 4'h8 : 4'h7)) ? 4'h0 : idx + 4'h1;
      end
   end
   // takes what the port sends as master, at each trailing edge
   always @(negedge lead or posedge frameRst) begin
      if (frameRst) begin
         tIdx <= 4'h0;
         mstWord <= 9'h000;
      end else begin
         mstWord[tIdx] <= dataLine;
         tIdx <= (tIdx == (nineBits ? 4'h8 : 4'h7)) ? 4'h0 : tIdx + 4'h1;
      end
   end
   // clock stands low between frames; exactly n cycles per frame
   task automatic slave_frame(input int n);
      for (int i = 0; i < n; i++) begin
         #24 linkClk = 1'b1;
         #24 linkClk = 1'b0;
         gotWord[i] = dataLine;
      end
   endtask
endmodule
`default_nettype wire

// ==== ssp_sync_port_tb_top.sv ====
/*
 Self-checking bench: master single, continuous, abort and overrun receive,
 single-mode overrun, port-enable clearing, master transmit, back-to-back
 slave transmit and a mid-run reset.
 Assumes ssp_pkg, ssp_sync_port and ssp_far_end are compiled first.
*/
`default_nettype none
module ssp_sync_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic nine; logic pl; logic [8:0] w;} ssp_row_t;
   logic core_clk = 1'b0, reset = 1'b1, linkClk, serialPortEn = 1'b0, clockedModeSel = 1'b0;
   logic clockSourceSel = 1'b0, continuousRxEn = 1'b0, singleRxSet = 1'b0, nineBitRxSel = 1'b0;
   logic nineBitTxSel = 1'b0, transmitEn = 1'b0, clockIdlePol = 1'b0, txWrite = 1'b0;
   logic [7:0] baudDivisorHigh = 8'h00, baudDivisorLow = 8'h05, txData = 8'h00, rxData;
   logic txNinthBit = 1'b0, rxRead = 1'b0, dataPinIn, dataPinOut, dataPinOe, clkPinOut;
   logic clkPinOe, rxNinthBit, rxReadyFlag, overrunFlag, singleRxEn, txBufEmptyFlag, tsrEmpty;
   logic frameRst = 1'b0, farData;
   logic [8:0] sendWord = 9'h000, gotWord, mstWord;
   int n_fail = 0, compares = 0;
   ssp_row_t rows [4] = '{'{1'b0, 1'b0, 9'h0A5}, '{1'b1, 1'b0, 9'h15A},
                          '{1'b1, 1'b1, 9'h0C3}, '{1'b0, 1'b1, 9'h13C}};
   always #25 core_clk = ~core_clk;
   assign dataPinIn = dataPinOe ? dataPinOut : farData;
   ssp_sync_port dut_u (.core_clk, .reset, .linkClk, .serialPortEn, .clockedModeSel,
      .clockSourceSel, .continuousRxEn, .singleRxSet, .nineBitRxSel, .nineBitTxSel,
      .transmitEn, .clockIdlePol, .baudDivisorHigh, .baudDivisorLow, .txWrite, .txData,
      .txNinthBit, .rxRead, .dataPinIn, .dataPinOut, .dataPinOe, .clkPinOut, .clkPinOe,
      .rxData, .rxNinthBit, .rxReadyFlag, .overrunFlag, .singleRxEn, .txBufEmptyFlag,
      .tsrEmpty);
   ssp_far_end far_u (.clkPin(clkPinOut), .idlePol(clockIdlePol), .frameRst(frameRst),
      .dataLine(dataPinIn), .sendWord(sendWord), .nineBits(nineBitRxSel),
      .farData(farData), .linkClk(linkClk), .gotWord(gotWord), .mstWord(mstWord));
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   // bounded wait; running out ends the run
   task automatic wait_hi(ref logic s, input int lim);
      int k;
      for (k = 0; k < lim && s !== 1'b1; k++) tick(1);
      if (s !== 1'b1) begin
         n_fail++;
         $display("MISMATCH wait timed out");
         test_done();
      end
   endtask
   initial begin
      tick(12);
      reset = 1'b0;
      chk("ready", 9'(rxReadyFlag), 9'h0);
      chk("overrun", 9'(overrunFlag), 9'h0);
      chk("txEmpty", 9'(txBufEmptyFlag), 9'h1);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h1);
      $display("reset test done");
      serialPortEn = 1'b1;
      clockedModeSel = 1'b1;
      clockSourceSel = 1'b1;
      transmitEn = 1'b1;
      foreach (rows[i]) begin
         nineBitRxSel = rows[i].nine;
         clockIdlePol = rows[i].pl;
         sendWord = rows[i].w;
         tick(4);
         pulse(frameRst);
         chk("clkIdle", 9'(clkPinOut), 9'(rows[i].pl));
         chk("clkOe", 9'(clkPinOe), 9'h1);
         pulse(singleRxSet);
         tick(2);
         chk("dataOe", 9'(dataPinOe), 9'h0);
         wait_hi(rxReadyFlag, 400);
         tick(1);
         chk("ninth", 9'(rxNinthBit), rows[i].nine ? 9'(rows[i].w[8]) : 9'h0);
         chk("rxData", 9'(rxData), 9'(rows[i].w[7:0]));
         chk("single", 9'(singleRxEn), 9'h0);
         repeat (40) begin tick(1); chk("noClk", 9'(clkPinOut), 9'(rows[i].pl)); end
         pulse(rxRead);
         tick(1);
         chk("ready", 9'(rxReadyFlag), 9'h0);
      end
      $display("single receive table done");
      clockIdlePol = 1'b0;
      nineBitRxSel = 1'b0;
      sendWord = 9'h03C;
      tick(4);
      pulse(frameRst);
      continuousRxEn = 1'b1;
      wait_hi(overrunFlag, 2000);
      tick(2);
      repeat (40) begin tick(1); chk("stalled", 9'(clkPinOut), 9'h0); end
      continuousRxEn = 1'b0;
      tick(2);
      chk("overrun", 9'(overrunFlag), 9'h0);
      chk("rxData", 9'(rxData), 9'h03C);
      pulse(rxRead);
      tick(1);
      chk("ready", 9'(rxReadyFlag), 9'h1);
      pulse(rxRead);
      tick(1);
      chk("ready", 9'(rxReadyFlag), 9'h0);
      pulse(frameRst);
      repeat (2) begin pulse(singleRxSet); tick(130); end
      pulse(singleRxSet);
      wait_hi(overrunFlag, 400);
      tick(2);
      chk("rxData", 9'(rxData), 9'h03C);
      pulse(rxRead);
      chk("ovrRead", 9'(overrunFlag), 9'h0);
      chk("ready", 9'(rxReadyFlag), 9'h1);
      pulse(rxRead);
      chk("ready", 9'(rxReadyFlag), 9'h0);
      $display("overrun test done");
      pulse(frameRst);
      continuousRxEn = 1'b1;
      tick(30);
      continuousRxEn = 1'b0;
      tick(2);
      repeat (60) begin tick(1); chk("abort", 9'(clkPinOut), 9'h0); end
      chk("ready", 9'(rxReadyFlag), 9'h0);
      pulse(frameRst);
      continuousRxEn = 1'b1;
      wait_hi(overrunFlag, 2000);
      serialPortEn = 1'b0;
      tick(2);
      chk("overrun", 9'(overrunFlag), 9'h0);
      chk("ready", 9'(rxReadyFlag), 9'h0);
      continuousRxEn = 1'b0;
      serialPortEn = 1'b1;
      $display("abort and disable test done");
      pulse(frameRst);
      txData = 8'h96;
      pulse(txWrite);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h0);
      chk("dataOe", 9'(dataPinOe), 9'h1);
      wait_hi(tsrEmpty, 400);
      tick(10);
      chk("mstTx", 9'(mstWord[7:0]), 9'h096);
      chk("clkIdle", 9'(clkPinOut), 9'h0);
      $display("master transmit test done");
      clockSourceSel = 1'b0;
      nineBitTxSel = 1'b1;
      tick(2);
      chk("clkOe", 9'(clkPinOe), 9'h0);
      txNinthBit = 1'b1;
      txData = 8'hA7;
      txWrite = 1'b1;
      tick(1);
      txNinthBit = 1'b0;
      txData = 8'h5C;
      tick(1);
      txWrite = 1'b0;
      tick(2);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h0);
      chk("txEmpty", 9'(txBufEmptyFlag), 9'h0);
      chk("dataOe", 9'(dataPinOe), 9'h1);
      #7 far_u.slave_frame(9);
      chk("slave1", gotWord, 9'h1A7);
      tick(10);
      chk("txEmpty", 9'(txBufEmptyFlag), 9'h1);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h0);
      #7 far_u.slave_frame(9);
      chk("slave2", gotWord, 9'h05C);
      tick(10);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h1);
      $display("slave transmit test done");
      pulse(txWrite);
      chk("tsrEmpty", 9'(tsrEmpty), 9'h0);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      chk("tsrEmpty", 9'(tsrEmpty), 9'h1);
      chk("txEmpty", 9'(txBufEmptyFlag), 9'h1);
      tick(2);
      chk("ready", 9'(rxReadyFlag), 9'h0);
      chk("clkOe", 9'(clkPinOe), 9'h0);
      $display("mid-run reset test done");
      test_done();
   end
endmodule
`default_nettype wire
